/* design/line_interface_register_bank.sv */
/*
 * register bank of the single channel line interface: control, status, interrupt
 * flag and error count registers behind the serial host port.
 * assumes status, event and counter inputs are synchronous to clk_sys.
 */
//
// Contract
// (R01) host writes reserved bits with their default values.
// (R02) read-only revision register at address zero, full eight bits.
// (R03) any write to address one resets all registers to defaults.
// (R04) reset register stores nothing; writing it only triggers reset.
// (R05) software reset also returns port status to defaults.
// (R06) after reset line drivers stay high impedance until enabled.
// (R07) interrupt drive: x0 open drain low, 01 push-pull low, 11 push-pull high.
// (R08) control, status and counter registers each at a fixed address.
// (R09) error count low byte at 1Bh, high byte at 1Ch.
// (R10) software reset completes within one microsecond.
// (R11) serial access is address/command byte then data byte.
// (R12) reading an interrupt flag register releases the interrupt output.
`timescale 1ns/1ps
module line_interface_register_bank
    import liu_regs_pkg::*;
#(
    // arbitrary revision value
    parameter logic [7:0] REVISION_CODE = 8'h5A
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // serial host port
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_write_input,
    output logic serial_read_output,
    output logic serial_read_oe_n,
    // interrupt pin
    output logic int_out,
    output logic int_oe_n,
    // line status and events
    input wire logic [4:0] line_status_in,
    input wire logic remote_loop_status_in,
    input wire logic [7:0] event_in,
    input wire logic [15:0] error_count_in,
    // configuration to the line logic
    output logic [7:0] line_impedance_select,
    output logic [7:0] jitter_attenuator_config,
    output logic [7:0] transmit_config_0,
    output logic [7:0] transmit_config_1,
    output logic [7:0] transmit_pulse_scaling,
    output logic [7:0] arbitrary_waveform_access,
    output logic [7:0] arbitrary_waveform_write_data,
    output logic [7:0] receive_config_0,
    output logic [7:0] receive_equalizer_los_config,
    output logic [7:0] receive_slicer_gain_config,
    output logic [7:0] diagnostic_pattern_config,
    output logic [7:0] loopback_select,
    output logic [7:0] error_counter_config,
    output logic driver_hiz,
    output logic soft_reset_busy
);

    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr_strobe;
    logic rd_strobe;
    logic [7:0] read_data;
    logic [7:0] next_read_data;
    logic [7:0] regs [0:31];
    logic [7:0] next_regs [0:31];
    logic [4:0] status_prev;
    logic [4:0] next_status_prev;
    logic [4:0] flags_0;
    logic [4:0] next_flags_0;
    logic [7:0] flags_1;
    logic [7:0] next_flags_1;
    logic [4:0] status_event;
    logic irq_active;
    logic next_irq_active;
    logic [4:0] reset_count;
    logic [4:0] next_reset_count;
    logic next_soft_reset_busy;
    logic next_driver_hiz;
    logic bank_rst;
    logic port_rst;

    // ---
    // helpers
    // ---
    function automatic logic is_writable(input logic [4:0] a);
        is_writable = (a >= ADDR_GLOBAL_CONFIG)
            && (a <= ADDR_INTERRUPT_EDGE_SELECT); // R08
    endfunction

    function automatic logic [7:0] default_value(input logic [4:0] a);
        case (a)
            ADDR_JITTER_ATTENUATOR_CONFIG: default_value = RESET_JITTER_ATTENUATOR_CONFIG;
            ADDR_TRANSMIT_CONFIG_1: default_value = RESET_TRANSMIT_CONFIG_1; // R06
            default: default_value = RESET_ZERO;
        endcase
    endfunction

    assign bank_rst = rst | soft_reset_busy; // R03
    assign port_rst = rst | soft_reset_busy; // R05

    // ---
    // host port and interrupt pin
    // ---
    serial_port u_serial_port (
        .clk_sys(clk_sys),
        .rst(port_rst),
        .sclk(sclk),
        .cs_n(cs_n),
        .serial_write_input(serial_write_input),
        .serial_read_output(serial_read_output),
        .serial_read_oe_n(serial_read_oe_n),
        .addr(addr),
        .wdata(wdata),
        .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe),
        .rdata(read_data)
    );

    interrupt_pin_driver u_interrupt_pin_driver (
        .clk_sys(clk_sys),
        .rst(bank_rst),
        .drive_select(regs[ADDR_GLOBAL_CONFIG][INT_DRIVE_MSB:INT_DRIVE_LSB]),
        .active(irq_active),
        .int_out(int_out),
        .int_oe_n(int_oe_n)
    );

    // ---
    // software reset sequencing
    // ---
    always_comb
    begin
        next_reset_count = reset_count;
        next_soft_reset_busy = soft_reset_busy;
        if (wr_strobe && addr == ADDR_SOFT_RESET_TRIGGER && !soft_reset_busy)
        begin
            next_reset_count = SOFT_RESET_CYCLES - 5'd1; // R10
            next_soft_reset_busy = 1'b1; // R03
        end
        else if (soft_reset_busy)
        begin
            if (reset_count == 5'd0)
            begin
                next_soft_reset_busy = 1'b0; // R10
            end
            else
            begin
                next_reset_count = reset_count - 5'd1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            reset_count <= 5'd0;
            soft_reset_busy <= 1'b0;
        end
        else
        begin
            reset_count <= next_reset_count;
            soft_reset_busy <= next_soft_reset_busy;
        end
    end

    // ---
    // control registers
    // ---
    always_comb
    begin
        for (int i = 0; i < 32; i++)
        begin
            next_regs[i] = regs[i];
        end
        if (wr_strobe && is_writable(addr))
        begin
            next_regs[addr] = wdata;
        end
        next_driver_hiz = next_regs[ADDR_TRANSMIT_CONFIG_1][TX_HIGH_IMPEDANCE_BIT]
            | next_regs[ADDR_TRANSMIT_CONFIG_0][TX_POWER_DOWN_BIT]; // R06
    end

    always_ff @(posedge clk_sys)
    begin
        if (bank_rst)
        begin
            for (int i = 0; i < 32; i++)
            begin
                regs[i] <= default_value(5'(i)); // R03
            end
            driver_hiz <= 1'b1; // R06
        end
        else
        begin
            for (int i = 0; i < 32; i++)
            begin
                regs[i] <= next_regs[i];
            end
            driver_hiz <= next_driver_hiz;
        end
    end

    assign line_impedance_select = regs[ADDR_LINE_IMPEDANCE_SELECT];
    assign jitter_attenuator_config = regs[ADDR_JITTER_ATTENUATOR_CONFIG];
    assign transmit_config_0 = regs[ADDR_TRANSMIT_CONFIG_0];
    assign transmit_config_1 = regs[ADDR_TRANSMIT_CONFIG_1];
    assign transmit_pulse_scaling = regs[ADDR_TRANSMIT_PULSE_SCALING];
    assign arbitrary_waveform_access = regs[ADDR_ARBITRARY_WAVEFORM_ACCESS];
    assign arbitrary_waveform_write_data = regs[ADDR_ARBITRARY_WAVEFORM_WRITE_DATA];
    assign receive_config_0 = regs[ADDR_RECEIVE_CONFIG_0];
    assign receive_equalizer_los_config = regs[ADDR_RECEIVE_EQUALIZER_LOS_CONFIG];
    assign receive_slicer_gain_config = regs[ADDR_RECEIVE_SLICER_GAIN_CONFIG];
    assign diagnostic_pattern_config = regs[ADDR_DIAGNOSTIC_PATTERN_CONFIG];
    assign loopback_select = regs[ADDR_LOOPBACK_SELECT];
    assign error_counter_config = regs[ADDR_ERROR_COUNTER_CONFIG];

    // ---
    // interrupt flags
    // ---
    always_comb
    begin
        next_status_prev = line_status_in;
        // edge select 0: rising edge only, 1: both edges
        status_event = (line_status_in & ~status_prev)
            | (regs[ADDR_INTERRUPT_EDGE_SELECT][STATUS_0_WIDTH-1:0] & ~line_status_in & status_prev);
        next_flags_0 = flags_0;
        next_flags_1 = flags_1;
        if (rd_strobe && addr == ADDR_INTERRUPT_FLAGS_0)
        begin
            next_flags_0 = 5'h00; // R12
        end
        if (rd_strobe && addr == ADDR_INTERRUPT_FLAGS_1)
        begin
            next_flags_1 = 8'h00; // R12
        end
        next_flags_0 = next_flags_0 | status_event;
        next_flags_1 = next_flags_1 | event_in;
        next_irq_active = |(next_flags_0 & regs[ADDR_INTERRUPT_MASK_0][STATUS_0_WIDTH-1:0])
            | |(next_flags_1 & regs[ADDR_INTERRUPT_MASK_1]);
    end

    always_ff @(posedge clk_sys)
    begin
        if (bank_rst)
        begin
            status_prev <= line_status_in;
            flags_0 <= 5'h00;
            flags_1 <= 8'h00;
            irq_active <= 1'b0;
        end
        else
        begin
            status_prev <= next_status_prev;
            flags_0 <= next_flags_0;
            flags_1 <= next_flags_1;
            irq_active <= next_irq_active;
        end
    end

    // ---
    // read decode
    // ---
    always_comb
    begin
        next_read_data = read_data;
        if (rd_strobe)
        begin
            case (addr)
                ADDR_SILICON_REVISION: next_read_data = REVISION_CODE; // R02
                ADDR_SOFT_RESET_TRIGGER: next_read_data = RESET_ZERO; // R04
                ADDR_LINE_STATUS_0: next_read_data = {3'b000, line_status_in}; // R08
                ADDR_LINE_STATUS_1: next_read_data = 8'(remote_loop_status_in) << REMOTE_LOOP_STATUS_BIT;
                ADDR_INTERRUPT_FLAGS_0: next_read_data = {3'b000, flags_0};
                ADDR_INTERRUPT_FLAGS_1: next_read_data = flags_1;
                ADDR_ERROR_COUNT_LOW: next_read_data = error_count_in[7:0]; // R09
                ADDR_ERROR_COUNT_HIGH: next_read_data = error_count_in[15:8]; // R09
                default:
                begin
                    next_read_data = is_writable(addr) ? regs[addr]
                        : RESET_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (bank_rst)
        begin
            read_data <= 8'h00;
        end
        else
        begin
            read_data <= next_read_data;
        end
    end

endmodule // line_interface_register_bank

/* design/liu_regs_pkg.sv */
/*
 * constants of the line interface register bank: register offsets, field positions,
 * reset values and the software reset timing.
 * assumes one system clock of 20 MHz.
 */
package liu_regs_pkg;

    // ---
    // register offsets
    // ---
    localparam logic [4:0] ADDR_SILICON_REVISION = 5'h00;
    localparam logic [4:0] ADDR_SOFT_RESET_TRIGGER = 5'h01;
    localparam logic [4:0] ADDR_GLOBAL_CONFIG = 5'h02;
    localparam logic [4:0] ADDR_LINE_IMPEDANCE_SELECT = 5'h03;
    localparam logic [4:0] ADDR_JITTER_ATTENUATOR_CONFIG = 5'h04;
    localparam logic [4:0] ADDR_TRANSMIT_CONFIG_0 = 5'h05;
    localparam logic [4:0] ADDR_TRANSMIT_CONFIG_1 = 5'h06;
    localparam logic [4:0] ADDR_TRANSMIT_PULSE_SCALING = 5'h07;
    localparam logic [4:0] ADDR_ARBITRARY_WAVEFORM_ACCESS = 5'h08;
    localparam logic [4:0] ADDR_ARBITRARY_WAVEFORM_WRITE_DATA = 5'h09;
    localparam logic [4:0] ADDR_RECEIVE_CONFIG_0 = 5'h0A;
    localparam logic [4:0] ADDR_RECEIVE_EQUALIZER_LOS_CONFIG = 5'h0B;
    localparam logic [4:0] ADDR_RECEIVE_SLICER_GAIN_CONFIG = 5'h0C;
    localparam logic [4:0] ADDR_DIAGNOSTIC_PATTERN_CONFIG = 5'h0D;
    localparam logic [4:0] ADDR_LOOPBACK_SELECT = 5'h0E;
    localparam logic [4:0] ADDR_ERROR_COUNTER_CONFIG = 5'h13;
    localparam logic [4:0] ADDR_INTERRUPT_MASK_0 = 5'h14;
    localparam logic [4:0] ADDR_INTERRUPT_MASK_1 = 5'h15;
    localparam logic [4:0] ADDR_INTERRUPT_EDGE_SELECT = 5'h16;
    localparam logic [4:0] ADDR_LINE_STATUS_0 = 5'h17;
    localparam logic [4:0] ADDR_LINE_STATUS_1 = 5'h18;
    localparam logic [4:0] ADDR_INTERRUPT_FLAGS_0 = 5'h19;
    localparam logic [4:0] ADDR_INTERRUPT_FLAGS_1 = 5'h1A;
    localparam logic [4:0] ADDR_ERROR_COUNT_LOW = 5'h1B;
    localparam logic [4:0] ADDR_ERROR_COUNT_HIGH = 5'h1C;

    // ---
    // reset values: zero, and those of the registers with a non-zero default
    // ---
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_JITTER_ATTENUATOR_CONFIG = 8'h20;
    localparam logic [7:0] RESET_TRANSMIT_CONFIG_1 = 8'h10;

    // ---
    // field positions
    // ---
    localparam int INT_DRIVE_LSB = 0;
    localparam int INT_DRIVE_MSB = 1;
    localparam int TX_POWER_DOWN_BIT = 4;
    localparam int TX_HIGH_IMPEDANCE_BIT = 4;
    localparam int REMOTE_LOOP_STATUS_BIT = 5;
    localparam int STATUS_0_WIDTH = 5;

    // ---
    // serial word layout
    // ---
    localparam logic [4:0] SERIAL_ADDR_BITS = 5'h08;
    localparam logic [4:0] SERIAL_WORD_BITS = 5'h10;
    localparam int SERIAL_RW_BIT = 0;
    localparam int SERIAL_ADDR_LSB = 1;
    localparam int SERIAL_ADDR_MSB = 5;

    // ---
    // software reset timing
    // ---
    localparam int CLK_PERIOD_NS = 50;
    localparam int SOFT_RESET_TIME_NS = 1000;
    localparam logic [4:0] SOFT_RESET_CYCLES = 5'(SOFT_RESET_TIME_NS / CLK_PERIOD_NS);

endpackage

/* design/serial_port.sv */
/*
 * serial host port: 16-bit word, address/command byte then data byte, lsb first.
 * assumes sclk and cs_n are synchronous to clk_sys and far slower than it.
 */
`timescale 1ns/1ps
module serial_port
    import liu_regs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // host pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_write_input,
    output logic serial_read_output,
    output logic serial_read_oe_n,
    // register side
    output logic [4:0] addr,
    output logic [7:0] wdata,
    output logic wr_strobe,
    output logic rd_strobe,
    input wire logic [7:0] rdata
);

    typedef enum logic [1:0] {PORT_IDLE, PORT_ADDR, PORT_DATA} port_state_t;

    port_state_t state, next_state;
    logic sclk_prev, next_sclk_prev;
    logic [4:0] count, next_count;
    logic [7:0] shift_in, next_shift_in;
    logic [7:0] shift_out, next_shift_out;
    logic is_read, next_is_read;
    logic load_pending, next_load_pending;
    logic next_serial_read_output, next_serial_read_oe_n;
    logic [4:0] next_addr;
    logic [7:0] next_wdata;
    logic next_wr_strobe, next_rd_strobe;
    logic rise, fall;

    // ---
    // word assembly
    // ---
    always_comb
    begin
        rise = sclk & ~sclk_prev;
        fall = ~sclk & sclk_prev;
        next_state = state;
        next_sclk_prev = sclk;
        next_count = count;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_is_read = is_read;
        next_load_pending = rd_strobe;
        next_serial_read_output = serial_read_output;
        next_serial_read_oe_n = serial_read_oe_n;
        next_addr = addr;
        next_wdata = wdata;
        next_wr_strobe = 1'b0;
        next_rd_strobe = 1'b0;
        if (load_pending)
        begin
            next_shift_out = rdata;
        end
        if (cs_n)
        begin
            next_state = PORT_IDLE;
            next_count = 5'd0;
            next_serial_read_oe_n = 1'b1;
        end
        else
        begin
            case (state)
                PORT_IDLE:
                begin
                    next_state = PORT_ADDR;
                    next_count = 5'd0;
                end
                PORT_ADDR:
                begin
                    if (rise)
                    begin
                        next_shift_in = {serial_write_input, shift_in[7:1]}; // R11
                        next_count = count + 5'd1;
                        if (count + 5'd1 == SERIAL_ADDR_BITS)
                        begin
                            next_addr = next_shift_in[SERIAL_ADDR_MSB:SERIAL_ADDR_LSB]; // R11
                            next_is_read = next_shift_in[SERIAL_RW_BIT]; // R11
                            next_rd_strobe = next_shift_in[SERIAL_RW_BIT];
                            next_state = PORT_DATA;
                        end
                    end
                end
                PORT_DATA:
                begin
                    if (fall && is_read)
                    begin
                        next_serial_read_output = shift_out[0];
                        next_serial_read_oe_n = 1'b0;
                        next_shift_out = {1'b0, shift_out[7:1]};
                    end
                    if (rise && count < SERIAL_WORD_BITS)
                    begin
                        next_shift_in = {serial_write_input, shift_in[7:1]};
                        next_count = count + 5'd1;
                        if (count + 5'd1 == SERIAL_WORD_BITS && !is_read)
                        begin
                            next_wdata = next_shift_in; // R11
                            next_wr_strobe = 1'b1;
                        end
                    end
                end
                default:
                begin
                    next_state = PORT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state <= PORT_IDLE;
            sclk_prev <= 1'b0;
            count <= 5'd0;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            is_read <= 1'b0;
            load_pending <= 1'b0;
            serial_read_output <= 1'b0;
            serial_read_oe_n <= 1'b1;
            addr <= 5'h00;
            wdata <= 8'h00;
            wr_strobe <= 1'b0;
            rd_strobe <= 1'b0;
        end
        else
        begin
            state <= next_state;
            sclk_prev <= next_sclk_prev;
            count <= next_count;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            is_read <= next_is_read;
            load_pending <= next_load_pending;
            serial_read_output <= next_serial_read_output;
            serial_read_oe_n <= next_serial_read_oe_n;
            addr <= next_addr;
            wdata <= next_wdata;
            wr_strobe <= next_wr_strobe;
            rd_strobe <= next_rd_strobe;
        end
    end

endmodule // serial_port

/* design/interrupt_pin_driver.sv */
/*
 * interrupt pin driver: turns the interrupt level into the selected pin style.
 * assumes an external pull-up in open-drain style.
 */
`timescale 1ns/1ps
module interrupt_pin_driver
    import liu_regs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic [1:0] drive_select,
    input wire logic active,
    // pin
    output logic int_out,
    output logic int_oe_n
);

    logic next_int_out, next_int_oe_n;

    // ---
    // pin style
    // ---
    always_comb
    begin
        if (!drive_select[0])
        begin
            next_int_out = 1'b0; // R07
            next_int_oe_n = ~active; // R07
        end
        else if (!drive_select[1])
        begin
            next_int_out = ~active; // R07
            next_int_oe_n = 1'b0;
        end
        else
        begin
            next_int_out = active; // R07
            next_int_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            int_out <= 1'b0;
            int_oe_n <= 1'b1;
        end
        else
        begin
            int_out <= next_int_out;
            int_oe_n <= next_int_oe_n;
        end
    end

endmodule // interrupt_pin_driver

/* bench/liu_host_model.sv */
/* serial host model: sends 16-bit words lsb first, collects read bits. assumes a 50 ns clk_sys. */
`timescale 1ns/1ps
module liu_host_model (
    // clock
    input wire logic clk_sys,
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic serial_write_input,
    input wire logic serial_read_output
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_write_input = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // four clk_sys per sclk phase, cs_n released between words
    task automatic xfer(input logic rw, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] word;
        word = {d, 2'b00, a, rw};
        gap(1);
        cs_n = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            serial_write_input = word[i];
            gap(4);
            if (i > 7) q[i - 8] = serial_read_output;
            sclk = 1'b1;
            gap(4);
            sclk = 1'b0;
        end
        gap(4);
        cs_n = 1'b1;
        serial_write_input = ~word[15];
        gap(4);
    endtask
endmodule // liu_host_model

/* bench/liu_regs_chk.sv */
/* port checker of the register bank. assumes it is bound to the bank's top module. */
`timescale 1ns/1ps
module liu_regs_chk
    import liu_regs_pkg::*;
(
    input wire logic clk_sys, rst, sclk, cs_n, serial_read_output, serial_read_oe_n,
    input wire logic int_out, int_oe_n, driver_hiz, soft_reset_busy,
    input wire logic [7:0] transmit_config_0, transmit_config_1, jitter_attenuator_config, loopback_select
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence cs_idle;
        cs_n ##1 cs_n ##1 cs_n;
    endsequence
    sequence cfg_quiet;
        $stable(transmit_config_0) && $stable(transmit_config_1);
    endsequence
    reset_length_a:
        assert property ($rose(soft_reset_busy) |-> ##[1:20] !soft_reset_busy) else $error("soft reset too long");
    soft_defaults_a:
        assert property (soft_reset_busy |=> transmit_config_1 == RESET_TRANSMIT_CONFIG_1
            && jitter_attenuator_config == RESET_JITTER_ATTENUATOR_CONFIG) else $error("no defaults");
    port_defaults_a:
        assert property (soft_reset_busy ##4 soft_reset_busy |-> int_oe_n && driver_hiz && serial_read_oe_n)
            else $error("port not at default");
    read_hold_a:
        assert property ($changed(serial_read_output) && !serial_read_oe_n |-> !sclk) else $error("read bit moved");
    oe_release_a:
        assert property (cs_idle |-> serial_read_oe_n) else $error("read line driven while idle");
    int_style_a:
        assert property (int_oe_n |-> !int_out) else $error("released pin not low");
    stable_idle_a:
        assert property (cs_idle ##0 !soft_reset_busy |-> $stable(loopback_select) && $stable(transmit_config_0))
            else $error("config moved while idle");
    hiz_follows_a:
        assert property (cfg_quiet ##1 cfg_quiet |-> driver_hiz ==
            (transmit_config_0[TX_POWER_DOWN_BIT] | transmit_config_1[TX_HIGH_IMPEDANCE_BIT])) else $error("hiz wrong");
endmodule // liu_regs_chk
bind line_interface_register_bank liu_regs_chk u_liu_regs_chk (.clk_sys(clk_sys), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .serial_read_output(serial_read_output), .serial_read_oe_n(serial_read_oe_n),
    .int_out(int_out), .int_oe_n(int_oe_n), .driver_hiz(driver_hiz), .soft_reset_busy(soft_reset_busy),
    .transmit_config_0(transmit_config_0), .transmit_config_1(transmit_config_1),
    .jitter_attenuator_config(jitter_attenuator_config), .loopback_select(loopback_select));

/* bench/line_interface_register_bank_bench.sv */
/* self-checking bench of the register bank. assumes the host model drives the serial pins. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("Error %0t: %h vs %h", $time, g, e); end end
module line_interface_register_bank_bench;
    import liu_regs_pkg::*;
    localparam logic [7:0] REV = 8'hC3; // arbitrary revision value
    // writable bits per address, reserved bits zero
    localparam logic [7:0] WMASK [32] = '{8'h00, 8'h00, 8'h03, 8'h3F, 8'h3F, 8'h1F, 8'h3F, 8'h3F, 8'hFF, 8'h7F,
        8'h1F, 8'h5F, 8'h33, 8'h7F, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h1F, 8'hFF, 8'h1F,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic clk_sys = 1'b0, rst = 1'b1, remote_loop_status_in = 1'b0;
    logic [4:0] line_status_in = 5'h00;
    logic [7:0] event_in = 8'h00, tc1, rd, d;
    logic [15:0] error_count_in = 16'h0000;
    logic sclk, cs_n, s_in, s_out, s_oe_n, s_wire, int_out, int_oe_n, hiz, busy;
    logic [7:0] v [32];
    int miscompares = 0, n_compared = 0, n;
    always #25 clk_sys = ~clk_sys;
    assign s_wire = s_oe_n ? 1'bz : s_out;
    liu_host_model u_liu_host_model (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .serial_write_input(s_in),
        .serial_read_output(s_wire));
    line_interface_register_bank #(.REVISION_CODE(REV)) u_line_interface_register_bank (.clk_sys(clk_sys),
        .rst(rst), .sclk(sclk), .cs_n(cs_n), .serial_write_input(s_in), .serial_read_output(s_out),
        .serial_read_oe_n(s_oe_n), .int_out(int_out), .int_oe_n(int_oe_n), .line_status_in(line_status_in),
        .remote_loop_status_in(remote_loop_status_in), .event_in(event_in), .error_count_in(error_count_in),
        .line_impedance_select(), .jitter_attenuator_config(), .transmit_config_0(), .transmit_config_1(tc1),
        .transmit_pulse_scaling(), .arbitrary_waveform_access(), .arbitrary_waveform_write_data(),
        .receive_config_0(), .receive_equalizer_los_config(), .receive_slicer_gain_config(),
        .diagnostic_pattern_config(), .loopback_select(), .error_counter_config(), .driver_hiz(hiz),
        .soft_reset_busy(busy));
    function automatic logic [7:0] dflt(input logic [4:0] a);
        return a == ADDR_JITTER_ATTENUATOR_CONFIG ? RESET_JITTER_ATTENUATOR_CONFIG :
            a == ADDR_TRANSMIT_CONFIG_1 ? RESET_TRANSMIT_CONFIG_1 : RESET_ZERO;
    endfunction
    // expected {int_oe_n, int_out}
    function automatic logic [1:0] pin(input logic [1:0] m, input logic act);
        return !m[0] ? {!act, 1'b0} : m[1] ? {1'b0, act} : {1'b0, !act};
    endfunction
    task automatic acc(input logic rw, input logic [4:0] a, input logic [7:0] wd);
        u_liu_host_model.xfer(rw, a, wd, rd);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        acc(1'b1, a, 8'h00);
        `CHK(rd, e)
    endtask
    task automatic defaults_chk();
        for (int a = 2; a < 32; a++) if (WMASK[a] != 8'h00) rchk(5'(a), dflt(5'(a)));
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        n = $urandom(31553);
        repeat (6) @(posedge clk_sys);
        #2 rst = 1'b0;
        rchk(ADDR_SILICON_REVISION, REV);
        rchk(ADDR_SOFT_RESET_TRIGGER, 8'h00);
        defaults_chk();
        `CHK(hiz, 1'b1)
        $display("reset defaults done");
        for (int a = 0; a < 32; a++) v[a] = (a == 0 || a > 22) ? 8'($urandom) : 8'($urandom) & WMASK[a];
        for (int a = 0; a < 32; a++) if (a != 1) acc(1'b0, 5'(a), v[a]);
        for (int a = 2; a < 23; a++) rchk(5'(a), v[a]);
        rchk(ADDR_SILICON_REVISION, REV);
        rchk(5'h1E, 8'h00);
        `CHK(tc1, v[6])
        `CHK(hiz, v[5][4] | v[6][4])
        line_status_in = 5'($urandom);
        remote_loop_status_in = 1'b1;
        error_count_in = 16'($urandom);
        rchk(ADDR_LINE_STATUS_0, {3'b000, line_status_in});
        rchk(ADDR_LINE_STATUS_1, 8'h20);
        rchk(ADDR_ERROR_COUNT_LOW, error_count_in[7:0]);
        rchk(ADDR_ERROR_COUNT_HIGH, error_count_in[15:8]);
        $display("read and write done");
        acc(1'b0, ADDR_INTERRUPT_MASK_0, 8'h00);
        acc(1'b0, ADDR_INTERRUPT_MASK_1, 8'hFF);
        acc(1'b1, ADDR_INTERRUPT_FLAGS_0, 8'h00);
        acc(1'b1, ADDR_INTERRUPT_FLAGS_1, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            d = 8'($urandom) | 8'h01;
            acc(1'b0, ADDR_GLOBAL_CONFIG, 8'(m));
            `CHK({int_oe_n, int_out}, pin(2'(m), 1'b0))
            event_in = d;
            @(posedge clk_sys);
            #2 event_in = 8'h00;
            repeat (4) @(posedge clk_sys);
            `CHK({int_oe_n, int_out}, pin(2'(m), 1'b1))
            rchk(ADDR_INTERRUPT_FLAGS_1, d);
            `CHK({int_oe_n, int_out}, pin(2'(m), 1'b0))
        end
        $display("interrupt pin done");
        acc(1'b0, ADDR_SOFT_RESET_TRIGGER, 8'($urandom));
        `CHK(busy, 1'b1)
        n = 0;
        while (busy === 1'b1 && n < 40)
        begin
            @(posedge clk_sys);
            #2 n++;
        end
        if (n == 40)
        begin
            miscompares++;
            summarize();
        end
        `CHK(n < 20, 1'b1)
        `CHK({tc1, hiz, int_oe_n}, {RESET_TRANSMIT_CONFIG_1, 2'b11})
        defaults_chk();
        rchk(ADDR_SOFT_RESET_TRIGGER, 8'h00);
        $display("soft reset done");
        summarize();
    end
endmodule // line_interface_register_bank_bench
